// ===== co_front.sv
// Gas sensor digital front: preheat, measurement loop, alarm pin, UART frames
`timescale 1ns/1ps
`default_nettype none
module co_front #(
    parameter int SEC_CYCLES = co_front_pkg::SEC_CYCLES,
    parameter int BIT_CYCLES = co_front_pkg::BIT_CYCLES,
    parameter logic [15:0] FW_VERSION = 16'h0100 // arbitrary value
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Converter side
    input wire co_front_pkg::sample_type sample_in,
    // Serial pins
    input wire logic rx_pin,
    output logic tx_pin,
    // Alarm pin and data outputs
    output logic alarm_level,
    output co_front_pkg::sample_type sample_out,
    output logic fault_flag,
    output logic warm_done
);

    // =====================================================================
    // Second timebase
    logic [31:0] sec_cnt_ff;
    logic sec_tick_ff;
    always_ff @(posedge clk_sys) begin
        if (srst || sec_cnt_ff == 32'(SEC_CYCLES - 1)) begin
            sec_cnt_ff <= '0;
        end else begin
            sec_cnt_ff <= sec_cnt_ff + 32'd1;
        end
        sec_tick_ff <= !srst && sec_cnt_ff == 32'(SEC_CYCLES - 1);
    end

    // =====================================================================
    // Configuration from host commands
    logic [15:0] alarm_thr_ff;
    logic [7:0] exit_ppm_ff;
    logic [15:0] preheat_cfg_ff;
    logic auto_en_ff;
    logic cmd_done;
    logic [7:0] cmd_op_ff;
    logic [7:0] cmd_hi_ff;
    logic [7:0] rx_byte_ff;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            alarm_thr_ff <= co_front_pkg::ALARM_PPM_DEF;
            exit_ppm_ff <= co_front_pkg::EXIT_PPM_DEF;
            preheat_cfg_ff <= 16'(co_front_pkg::PREHEAT_S);
            auto_en_ff <= 1'b1;
        end else if (cmd_done) begin
            case (cmd_op_ff)
                co_front_pkg::OP_SET_ALARM: alarm_thr_ff <= {cmd_hi_ff, rx_byte_ff};
                co_front_pkg::OP_SET_EXIT: exit_ppm_ff <= rx_byte_ff;
                co_front_pkg::OP_SET_PREHEAT: preheat_cfg_ff <= {cmd_hi_ff, rx_byte_ff};
                co_front_pkg::OP_AUTO: auto_en_ff <= rx_byte_ff[0];
                default: ;
            endcase
        end
    end

    // =====================================================================
    // Measurement sequencer
    co_front_pkg::seq_type seq_ff;
    logic [15:0] warm_left_ff;
    logic [2:0] deb_cnt_ff;
    logic auto_req;
    logic [11:0] ref_raw_ff;
    logic ref_seen_ff;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            seq_ff <= co_front_pkg::SQ_INIT;
        end else begin
            case (seq_ff)
                co_front_pkg::SQ_INIT: seq_ff <= co_front_pkg::SQ_PREHEAT;
                co_front_pkg::SQ_PREHEAT: begin
                    if (warm_left_ff == 16'h0000) begin
                        seq_ff <= co_front_pkg::SQ_STATUS;
                    end
                end
                co_front_pkg::SQ_STATUS: seq_ff <= co_front_pkg::SQ_SAMPLE;
                co_front_pkg::SQ_SAMPLE: seq_ff <= co_front_pkg::SQ_FAULT;
                co_front_pkg::SQ_FAULT: seq_ff <= co_front_pkg::SQ_ALARM;
                co_front_pkg::SQ_ALARM: seq_ff <= co_front_pkg::SQ_WAIT;
                co_front_pkg::SQ_WAIT: begin
                    if (sec_tick_ff) begin
                        seq_ff <= co_front_pkg::SQ_STATUS;
                    end
                end
                default: seq_ff <= co_front_pkg::SQ_INIT;
            endcase
        end
    end

    // Preheat countdown; a new preheat time restarts a running preheat
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            warm_left_ff <= '0;
            warm_done <= 1'b0;
        end else if (seq_ff == co_front_pkg::SQ_INIT) begin
            warm_left_ff <= preheat_cfg_ff;
        end else if (seq_ff == co_front_pkg::SQ_PREHEAT) begin
            if (cmd_done && cmd_op_ff == co_front_pkg::OP_SET_PREHEAT) begin
                warm_left_ff <= {cmd_hi_ff, rx_byte_ff};
            end else if (sec_tick_ff && warm_left_ff != 16'h0000) begin
                warm_left_ff <= warm_left_ff - 16'd1;
            end
            warm_done <= warm_left_ff == 16'h0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sample_out <= '0;
            ref_raw_ff <= '0;
            ref_seen_ff <= 1'b0;
        end else if (seq_ff == co_front_pkg::SQ_SAMPLE) begin
            sample_out <= sample_in;
            if (!ref_seen_ff) begin
                ref_raw_ff <= sample_in.raw;
                ref_seen_ff <= 1'b1;
            end
        end
    end

    // A stuck converter at either rail reads as a sensor fault
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fault_flag <= 1'b0;
        end else if (seq_ff == co_front_pkg::SQ_FAULT) begin
            fault_flag <= sample_out.raw == co_front_pkg::RAW_FLOOR || sample_out.raw == co_front_pkg::RAW_CEIL;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            alarm_level <= 1'b0;
            deb_cnt_ff <= '0;
        end else if (seq_ff == co_front_pkg::SQ_ALARM) begin
            if (!alarm_level) begin
                if (sample_out.ppm >= alarm_thr_ff) begin
                    deb_cnt_ff <= deb_cnt_ff + 3'd1;
                    if (deb_cnt_ff == 3'(co_front_pkg::DEBOUNCE_S - 1)) begin
                        alarm_level <= 1'b1;
                        deb_cnt_ff <= '0;
                    end
                end else begin
                    deb_cnt_ff <= '0;
                end
            end else if (sample_out.ppm <= {8'h00, exit_ppm_ff}) begin
                deb_cnt_ff <= deb_cnt_ff + 3'd1;
                if (deb_cnt_ff == 3'(co_front_pkg::DEBOUNCE_S - 1)) begin
                    alarm_level <= 1'b0;
                    deb_cnt_ff <= '0;
                end
            end else begin
                deb_cnt_ff <= '0;
            end
        end else if (seq_ff == co_front_pkg::SQ_PREHEAT || seq_ff == co_front_pkg::SQ_INIT) begin
            alarm_level <= 1'b0;
            deb_cnt_ff <= '0;
        end
    end

    // =====================================================================
    // Frame generator
    logic frame_pend_ff;
    logic gen_busy_ff;
    logic [4:0] gen_idx_ff;
    logic [7:0] gen_sum_ff;
    logic [7:0] gen_byte;
    logic gen_push;
    logic buf_ready;
    logic query_done;
    assign auto_req = seq_ff == co_front_pkg::SQ_STATUS && auto_en_ff;
    assign query_done = cmd_done && cmd_op_ff == co_front_pkg::OP_QUERY;
    assign gen_push = gen_busy_ff && buf_ready;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            frame_pend_ff <= 1'b0;
        end else if (auto_req || query_done) begin
            frame_pend_ff <= 1'b1;
        end else if (!gen_busy_ff) begin
            frame_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gen_busy_ff <= 1'b0;
            gen_idx_ff <= '0;
            gen_sum_ff <= '0;
        end else if (!gen_busy_ff) begin
            gen_busy_ff <= frame_pend_ff;
            gen_idx_ff <= '0;
            gen_sum_ff <= '0;
        end else if (gen_push) begin
            gen_sum_ff <= gen_sum_ff + gen_byte;
            gen_idx_ff <= gen_idx_ff + 5'd1;
            gen_busy_ff <= gen_idx_ff != co_front_pkg::IDX_LAST;
        end
    end

    always_comb begin
        case (gen_idx_ff)
            5'd0: gen_byte = co_front_pkg::HDR_0;
            5'd1: gen_byte = co_front_pkg::HDR_1;
            5'd2: gen_byte = co_front_pkg::HDR_2;
            5'd3: gen_byte = co_front_pkg::HDR_3;
            5'd4: gen_byte = co_front_pkg::HDR_4;
            5'd5: gen_byte = {4'h0, sample_out.raw[11:8]};
            5'd6: gen_byte = sample_out.raw[7:0];
            5'd7: gen_byte = {4'h0, ref_raw_ff[11:8]};
            5'd8: gen_byte = ref_raw_ff[7:0];
            5'd9: gen_byte = sample_out.ppm[15:8];
            5'd10: gen_byte = sample_out.ppm[7:0];
            5'd12: gen_byte = {7'h00, warm_done};
            5'd13: gen_byte = {alarm_level, fault_flag, 6'h00};
            5'd14: gen_byte = warm_left_ff[7:0];
            5'd20: gen_byte = co_front_pkg::CAL_OK;
            5'd21: gen_byte = alarm_thr_ff[15:8];
            5'd22: gen_byte = alarm_thr_ff[7:0];
            5'd23: gen_byte = exit_ppm_ff;
            5'd29: gen_byte = FW_VERSION[15:8];
            5'd30: gen_byte = FW_VERSION[7:0];
            co_front_pkg::IDX_LAST: gen_byte = 8'h00 - gen_sum_ff;
            default: gen_byte = 8'h00;
        endcase
    end

    // =====================================================================
    // Two-entry buffer between generator and transmitter
    logic [7:0] buf_mem [2];
    logic buf_wp_ff;
    logic buf_rp_ff;
    logic [1:0] buf_cnt_ff;
    logic buf_pop;
    assign buf_ready = buf_cnt_ff != 2'd2;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            buf_wp_ff <= 1'b0;
            buf_rp_ff <= 1'b0;
            buf_cnt_ff <= '0;
        end else begin
            if (gen_push) begin
                buf_mem[buf_wp_ff] <= gen_byte;
                buf_wp_ff <= !buf_wp_ff;
            end
            if (buf_pop) begin
                buf_rp_ff <= !buf_rp_ff;
            end
            buf_cnt_ff <= buf_cnt_ff + {1'b0, gen_push} - {1'b0, buf_pop};
        end
    end

    // =====================================================================
    // Transmitter
    logic tx_busy_ff;
    logic [9:0] tx_shift_ff;
    logic [3:0] tx_bits_ff;
    logic [31:0] tx_cnt_ff;
    assign buf_pop = !tx_busy_ff && buf_cnt_ff != 2'd0;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx_pin <= 1'b1;
            tx_busy_ff <= 1'b0;
            tx_shift_ff <= '1;
            tx_bits_ff <= '0;
            tx_cnt_ff <= '0;
        end else if (buf_pop) begin
            tx_pin <= 1'b0;
            // Data in the low byte, stop bit above it; ones shift in behind
            tx_shift_ff <= {2'b01, buf_mem[buf_rp_ff]};
            tx_busy_ff <= 1'b1;
            tx_bits_ff <= '0;
            tx_cnt_ff <= '0;
        end else if (tx_busy_ff) begin
            if (tx_cnt_ff == 32'(BIT_CYCLES - 1)) begin
                tx_cnt_ff <= '0;
                tx_bits_ff <= tx_bits_ff + 4'd1;
                tx_pin <= tx_bits_ff == 4'd9 ? 1'b1 : tx_shift_ff[0];
                tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
                tx_busy_ff <= tx_bits_ff != 4'd9;
            end else begin
                tx_cnt_ff <= tx_cnt_ff + 32'd1;
            end
        end
    end

    // =====================================================================
    // Receiver and command parser
    logic rx_s1_ff;
    logic rx_s2_ff;
    logic rx_s3_ff;
    co_front_pkg::rx_state_type rx_st_ff;
    logic [31:0] rx_cnt_ff;
    logic [2:0] rx_bit_ff;
    logic rx_got_ff;
    logic [1:0] cmd_idx_ff;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
            rx_s3_ff <= 1'b1;
        end else begin
            rx_s1_ff <= rx_pin;
            rx_s2_ff <= rx_s1_ff;
            rx_s3_ff <= rx_s2_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        rx_got_ff <= 1'b0;
        if (srst) begin
            rx_st_ff <= co_front_pkg::RX_IDLE;
            rx_cnt_ff <= '0;
            rx_bit_ff <= '0;
            rx_byte_ff <= '0;
        end else begin
            rx_cnt_ff <= rx_cnt_ff + 32'd1;
            case (rx_st_ff)
                co_front_pkg::RX_IDLE: begin
                    rx_cnt_ff <= '0;
                    if (rx_s3_ff && !rx_s2_ff) begin
                        rx_st_ff <= co_front_pkg::RX_START;
                    end
                end
                co_front_pkg::RX_START: begin
                    if (rx_cnt_ff == 32'(BIT_CYCLES / 2)) begin
                        rx_cnt_ff <= '0;
                        rx_bit_ff <= '0;
                        rx_st_ff <= rx_s2_ff ? co_front_pkg::RX_IDLE : co_front_pkg::RX_DATA;
                    end
                end
                co_front_pkg::RX_DATA: begin
                    if (rx_cnt_ff == 32'(BIT_CYCLES - 1)) begin
                        rx_cnt_ff <= '0;
                        rx_byte_ff <= {rx_s2_ff, rx_byte_ff[7:1]};
                        rx_bit_ff <= rx_bit_ff + 3'd1;
                        if (rx_bit_ff == 3'd7) begin
                            rx_st_ff <= co_front_pkg::RX_STOP;
                        end
                    end
                end
                co_front_pkg::RX_STOP: begin
                    if (rx_cnt_ff == 32'(BIT_CYCLES - 1)) begin
                        rx_got_ff <= rx_s2_ff;
                        rx_st_ff <= co_front_pkg::RX_IDLE;
                    end
                end
                default: rx_st_ff <= co_front_pkg::RX_IDLE;
            endcase
        end
    end

    assign cmd_done = rx_got_ff && cmd_idx_ff == co_front_pkg::CMD_LAST;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cmd_idx_ff <= '0;
            cmd_op_ff <= '0;
            cmd_hi_ff <= '0;
        end else if (rx_got_ff) begin
            if (cmd_idx_ff == 2'd0) begin
                cmd_op_ff <= rx_byte_ff;
            end
            if (cmd_idx_ff == 2'd1) begin
                cmd_hi_ff <= rx_byte_ff;
            end
            cmd_idx_ff <= cmd_done ? 2'd0 : cmd_idx_ff + 2'd1;
        end
    end

    // =====================================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    warm_alarm_a: assert property (warm_done == 1'b0 |-> alarm_level == 1'b0)
        else $error("alarm high during preheat");
    alarm_idle_a: assert property ($fell(alarm_level) |-> $past(seq_ff) == co_front_pkg::SQ_ALARM
        || $past(seq_ff) == co_front_pkg::SQ_PREHEAT)
        else $error("alarm dropped outside evaluation");
    alarm_rise_a: assert property ($rose(alarm_level) |-> $past(sample_out.ppm) >= $past(alarm_thr_ff))
        else $error("alarm rose below threshold");
    alarm_deb_a: assert property ($rose(alarm_level) |-> $past(deb_cnt_ff) == 3'(co_front_pkg::DEBOUNCE_S - 1))
        else $error("alarm entered without debounce");
    loop_order_a: assert property (seq_ff == co_front_pkg::SQ_STATUS |=> seq_ff == co_front_pkg::SQ_SAMPLE
        ##1 seq_ff == co_front_pkg::SQ_FAULT ##1 seq_ff == co_front_pkg::SQ_ALARM)
        else $error("loop order broken");
    warm_gate_a: assert property (seq_ff == co_front_pkg::SQ_PREHEAT && warm_left_ff != 16'h0000
        |=> seq_ff == co_front_pkg::SQ_PREHEAT)
        else $error("left preheat early");
    sample_out_a: assert property (seq_ff == co_front_pkg::SQ_SAMPLE |=> sample_out == $past(sample_in))
        else $error("sample not captured");
    frame_head_a: assert property (gen_push && gen_idx_ff == 5'd0 |-> gen_byte == co_front_pkg::HDR_0)
        else $error("bad frame header");
    frame_sum_a: assert property (gen_push && gen_idx_ff == co_front_pkg::IDX_LAST
        |-> 8'(gen_byte + gen_sum_ff) == 8'h00)
        else $error("bad check byte");
    tx_start_a: assert property (buf_pop |=> tx_pin == 1'b0)
        else $error("no start bit");
    tx_idle_a: assert property (!tx_busy_ff && !$past(tx_busy_ff) |-> tx_pin == 1'b1)
        else $error("line not idle high");
    rx_wake_a: assert property (rx_st_ff == co_front_pkg::RX_IDLE && rx_s3_ff && !rx_s2_ff
        |=> rx_st_ff == co_front_pkg::RX_START)
        else $error("receiver missed wake edge");
    cfg_apply_a: assert property (cmd_done && cmd_op_ff == co_front_pkg::OP_SET_ALARM
        |=> alarm_thr_ff == {$past(cmd_hi_ff), $past(rx_byte_ff)})
        else $error("threshold not applied");
    auto_frame_a: assert property (auto_req |=> frame_pend_ff)
        else $error("automatic frame not requested");

    alarm_seen_c: cover property ($rose(alarm_level));
    frame_done_c: cover property (gen_push && gen_idx_ff == co_front_pkg::IDX_LAST);
    cmd_seen_c: cover property (cmd_done);
    buf_full_c: cover property (buf_cnt_ff == 2'd2);

endmodule // co_front
`default_nettype wire

// ===== co_front_bench.sv
// Self-checking bench for the gas sensor front end
`timescale 1ns/1ps
`default_nettype none
module co_front_bench;
    // One second must hold a whole 32-byte frame
    localparam int SEC = 5400;
    localparam int BITC = 16;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    co_front_pkg::sample_type sample_in = '0;
    co_front_pkg::sample_type sample_out;
    logic rx_pin, tx_pin, alarm_level, fault_flag, warm_done, pre_alarm;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int f0;
    logic [15:0] thr_q[$];
    logic [7:0] hdr [5] = '{8'haa, 8'h20, 8'h21, 8'h01, 8'hac};
    co_front #(.SEC_CYCLES(SEC), .BIT_CYCLES(BITC)) i_dut (.clk_sys(clk_sys), .srst(srst),
        .sample_in(sample_in), .rx_pin(rx_pin), .tx_pin(tx_pin), .alarm_level(alarm_level),
        .sample_out(sample_out), .fault_flag(fault_flag), .warm_done(warm_done));
    co_host #(.BIT_CYCLES(BITC)) i_host (.clk_sys(clk_sys), .tx_pin(tx_pin), .rx_pin(rx_pin));
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic check(input logic [27:0] seen, input logic [27:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        // Whole run is about 13 loop periods; ceiling leaves margin
        if (cycles == 90000) begin
            num_errors++;
            end_of_test();
        end
    end
    // ====
    // Frame watcher
    initial begin
        logic [7:0] sum;
        forever begin
            @(i_host.frame_done);
            sum = '0;
            foreach (i_host.frame[i]) sum += i_host.frame[i];
            // A newer threshold note applies from this frame on
            if (thr_q.size() > 1) void'(thr_q.pop_front());
            for (int i = 0; i < 5; i++) check(i_host.frame[i], hdr[i]);
            check({i_host.frame[21], i_host.frame[22]}, thr_q[0]);
            check(sum, 8'h00);
        end
    end
    // ====
    // Main sequence
    initial begin
        void'($urandom(32'hce3d230c));
        thr_q.push_back(16'h00b4);
        sample_in = '{raw: 12'h100, ppm: 16'h01f4};
        repeat (20) @(negedge clk_sys);
        srst = 1'b0;
        // Shorten preheat to one second
        i_host.send_byte(8'h02);
        i_host.send_byte(8'h00);
        i_host.send_byte(8'h01);
        check(warm_done, 1'b0);
        pre_alarm = 1'b0;
        for (int i = 0; i < 3 * SEC && warm_done !== 1'b1; i++) begin
            @(negedge clk_sys);
            pre_alarm = pre_alarm | alarm_level;
        end
        check(warm_done, 1'b1);
        check(pre_alarm, 1'b0);
        $display("preheat test done");
        f0 = i_host.frames;
        sample_in.ppm = 16'h00b4;
        sample_in.raw = 12'($urandom_range(4094, 1));
        repeat (4 * SEC - 100) @(negedge clk_sys);
        check(alarm_level, 1'b0);
        repeat (2 * SEC) @(negedge clk_sys);
        check(alarm_level, 1'b1);
        check(sample_out, sample_in);
        check(fault_flag, 1'b0);
        $display("alarm rise test done");
        sample_in.ppm = 16'h0037;
        // Converter stuck at its top rail
        sample_in.raw = 12'hfff;
        // New threshold sent just after a frame, so the next frame carries it
        fork
            begin
                @(i_host.frame_done);
                @(negedge clk_sys);
                thr_q.push_back(16'h00c8);
                i_host.send_byte(8'h01);
                i_host.send_byte(8'h00);
                i_host.send_byte(8'hc8);
            end
        join_none
        repeat (4 * SEC - 100) @(negedge clk_sys);
        check(alarm_level, 1'b1);
        repeat (2 * SEC) @(negedge clk_sys);
        check(alarm_level, 1'b0);
        check(sample_out, sample_in);
        check(fault_flag, 1'b1);
        check(28'(i_host.frames - f0 inside {[11:13]}), 28'h1);
        check(28'(i_host.bad_bits), 28'h0);
        $display("alarm fall test done");
        end_of_test();
    end
endmodule // co_front_bench
`default_nettype wire

// ===== co_front_pkg.sv
// Constants and types for the gas sensor alarm and UART front end
package co_front_pkg;

    // =====================================================================
    // Timing
    localparam int CLK_HZ = 200_000_000;
    localparam int BAUD_BPS = 9600;
    localparam int SAMPLE_PERIOD_MS = 1000;
    localparam int SEC_CYCLES = (CLK_HZ / 1000) * SAMPLE_PERIOD_MS;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
    localparam int PREHEAT_S = 120;
    localparam int DEBOUNCE_S = 5;

    // =====================================================================
    // Defaults and limits
    localparam logic [15:0] ALARM_PPM_DEF = 16'h00b4;
    localparam logic [7:0] EXIT_PPM_DEF = 8'h37;
    localparam logic [11:0] RAW_FLOOR = 12'h000;
    localparam logic [11:0] RAW_CEIL = 12'hfff;

    // =====================================================================
    // Frame layout
    localparam int FRAME_LEN = 32;
    localparam logic [4:0] IDX_LAST = 5'h1f;
    localparam logic [7:0] HDR_0 = 8'haa;
    localparam logic [7:0] HDR_1 = 8'h20;
    localparam logic [7:0] HDR_2 = 8'h21;
    localparam logic [7:0] HDR_3 = 8'h01;
    localparam logic [7:0] HDR_4 = 8'hac;
    localparam logic [7:0] CAL_OK = 8'hac;
    localparam int BIT_DONE = 0;
    localparam int BIT_FAULT = 6;
    localparam int BIT_ALARM = 7;

    // =====================================================================
    // Command opcodes: opcode, high byte, low byte
    localparam logic [7:0] OP_SET_ALARM = 8'h01;
    localparam logic [7:0] OP_SET_PREHEAT = 8'h02;
    localparam logic [7:0] OP_SET_EXIT = 8'h03;
    localparam logic [7:0] OP_QUERY = 8'h04;
    localparam logic [7:0] OP_AUTO = 8'h05;
    localparam logic [1:0] CMD_LAST = 2'd2;

    typedef struct packed {
        logic [11:0] raw;
        logic [15:0] ppm;
    } sample_type;

    typedef enum logic [6:0] {
        SQ_INIT = 7'b0000001,
        SQ_PREHEAT = 7'b0000010,
        SQ_STATUS = 7'b0000100,
        SQ_SAMPLE = 7'b0001000,
        SQ_FAULT = 7'b0010000,
        SQ_ALARM = 7'b0100000,
        SQ_WAIT = 7'b1000000
    } seq_type;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_type;

endpackage

// ===== co_host.sv
// Host side model: UART sender and status frame collector
`timescale 1ns/1ps
`default_nettype none
module co_host #(
    parameter int BIT_CYCLES = 16
) (
    // Clock
    input wire logic clk_sys,
    // Serial pins
    input wire logic tx_pin,
    output var logic rx_pin
);
    logic [7:0] frame [32];
    int frames = 0;
    int bad_bits = 0;
    event frame_done;
    initial rx_pin = 1'b1;
    // ====
    // Sender
    // paced 8N1 bytes
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] sh;
        sh = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_sys);
            rx_pin = sh[i];
            repeat (BIT_CYCLES - 1) @(negedge clk_sys);
        end
    endtask
    // ====
    // Receiver, sampled mid-bit
    // start low, stop high
    initial begin
        logic [7:0] b;
        forever begin
            for (int n = 0; n < 32; n++) begin
                @(negedge tx_pin);
                repeat (BIT_CYCLES / 2) @(posedge clk_sys);
                if (tx_pin !== 1'b0) bad_bits++;
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYCLES) @(posedge clk_sys);
                    b[i] = tx_pin;
                end
                repeat (BIT_CYCLES) @(posedge clk_sys);
                if (tx_pin !== 1'b1) bad_bits++;
                frame[n] = b;
            end
            frames++;
            -> frame_done;
        end
    end
endmodule // co_host
`default_nettype wire
